/* rtl/scs_pkg.sv */
package scs_pkg;

  // channel count of modulator and analog threshold inputs
  localparam int unsigned CH_NUM = 8;
  localparam int unsigned CH_IDX_W = 3;

  // supervisor states
  typedef enum logic [1:0] {
    SCS_HELD,
    SCS_RUN,
    SCS_TRIP
  } scs_state_t;

  // status lamp colours
  typedef enum logic [1:0] {
    SCS_LAMP_ORANGE,
    SCS_LAMP_GREEN,
    SCS_LAMP_RED
  } scs_lamp_t;

  // fault category shown on the display
  typedef enum logic [1:0] {
    SCS_CAT_NONE,
    SCS_CAT_HW,
    SCS_CAT_SW,
    SCS_CAT_USER
  } scs_cat_t;

  // fault record latched on trip entry
  typedef struct packed {
    scs_cat_t             cat;
    logic                 thr_hit;
    logic [CH_IDX_W-1:0]  chan;
    logic                 ilk_lost;
  } scs_fault_t;

  // software error sources from the processor
  typedef struct packed {
    logic div_zero;
    logic stack_ovf;
    logic isr_one_overrun;
    logic isr_two_overrun;
  } scs_sw_err_t;

  // reset values
  localparam scs_state_t RST_STATE = SCS_HELD;
  localparam scs_fault_t RST_FAULT = '{SCS_CAT_NONE, 1'b0, 3'h0, 1'b0};
  localparam logic [CH_NUM-1:0] RST_GATE = 8'h00;
  localparam scs_lamp_t RST_LAMP = SCS_LAMP_ORANGE;
  localparam logic RST_PANEL = 1'b1;

endpackage

/* rtl/scs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser, output follows once stages two and three agree
module scs_sync #(
  parameter int unsigned W = 9
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import scs_pkg::*;

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // per bit: accept the new level only when the last two stages match
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // register chain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

`default_nettype wire

/* rtl/scs_core.sv */
// Behaviour
// - after startup, hold state with gates inhibited
// - no gate pulses before host enable
// - enable in hold: run, modulate, green lamp
// - disable inhibits; enable restores; not in trip, where enable is ignored
// - any fault trips at once, gates off
// - lamp orange hold, green run, red trip
// - threshold exceed is hardware fault, record channel
// - interlock loss is hardware fault
// - div zero, stack, isr overrun: software fault
// - hazard status from routine: user fault
// - trip: block, warn, red, hook, then hold
// - hardware blocks outputs before software handling
// - acknowledge only when fault inputs are clear
// - display shows fault category
// - panel config open in hold, locked run
// - gate needs channel active, running, no fault
`timescale 1ns/1ps
`default_nettype none

module scs_core (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       enable_cmd_in,
  input  wire logic                       disable_cmd_in,
  input  wire logic [scs_pkg::CH_NUM-1:0] thr_exceed_in,
  input  wire logic                       interlock_in,
  input  wire scs_pkg::scs_sw_err_t       sw_err_in,
  input  wire logic                       user_hazard_in,
  input  wire logic                       hook_done_in,
  input  wire logic [scs_pkg::CH_NUM-1:0] chan_active_in,
  input  wire logic [scs_pkg::CH_NUM-1:0] pwm_in,
  output logic      [scs_pkg::CH_NUM-1:0] gate_out,
  output scs_pkg::scs_lamp_t              lamp_out,
  output scs_pkg::scs_state_t             state_out,
  output scs_pkg::scs_fault_t             fault_out,
  output logic                            warn_out,
  output logic                            hook_invoke_out,
  output logic                            panel_unlock_out
);
  import scs_pkg::*;

  // lowest numbered set bit of a channel vector
  function automatic logic [CH_IDX_W-1:0] first_chan(input logic [CH_NUM-1:0] v);
    logic [CH_IDX_W-1:0] idx;
    idx = '0;
    for (int i = CH_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CH_IDX_W'(i);
      end
    end
    return idx;
  endfunction

  // colour for a state
  function automatic scs_lamp_t lamp_of(input scs_state_t s);
    case (s)
      SCS_RUN:  return SCS_LAMP_GREEN;
      SCS_TRIP: return SCS_LAMP_RED;
      default:  return SCS_LAMP_ORANGE;
    endcase
  endfunction

  logic [CH_NUM:0]   pins_sync;
  logic [CH_NUM-1:0] thr_sync;
  logic              ilk_lost;
  logic              hw_fault, sw_fault, fault_any;

  scs_state_t        state_q, state_d;
  scs_fault_t        fault_q, fault_d;
  scs_lamp_t         lamp_q, lamp_d;
  logic [CH_NUM-1:0] gate_q, gate_d;
  logic              warn_q, warn_d;
  logic              hook_q, hook_d;
  logic              panel_q, panel_d;

  // pin inputs: threshold comparators and inverted interlock life signal
  scs_sync #(
    .W (CH_NUM + 1)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({~interlock_in, thr_exceed_in}),
    .sync_out (pins_sync)
  );

  // fault sources
  assign thr_sync  = pins_sync[CH_NUM-1:0];
  assign ilk_lost  = pins_sync[CH_NUM];
  assign hw_fault  = (|thr_sync) | ilk_lost;
  assign sw_fault  = |sw_err_in;
  assign fault_any = hw_fault | sw_fault | user_hazard_in;

  // next state, fault record and output values
  always_comb begin
    state_d = state_q;
    fault_d = fault_q;
    warn_d  = 1'b0;
    hook_d  = 1'b0;
    case (state_q)
      SCS_HELD: begin
        if (enable_cmd_in) begin
          state_d = SCS_RUN;
        end
      end
      SCS_RUN: begin
        if (disable_cmd_in) begin
          state_d = SCS_HELD;
        end
      end
      SCS_TRIP: begin
        if (hook_done_in && !fault_any) begin
          state_d = SCS_HELD;
          fault_d = RST_FAULT;
        end
      end
      default: begin
        state_d = SCS_TRIP;
      end
    endcase
    // any fault overrides commands, also an enable in the same cycle
    if (fault_any && state_q != SCS_TRIP) begin
      state_d          = SCS_TRIP;
      warn_d           = 1'b1;
      hook_d           = 1'b1;
      fault_d.thr_hit  = |thr_sync;
      fault_d.chan     = first_chan(thr_sync);
      fault_d.ilk_lost = ilk_lost;
      if (hw_fault) begin
        fault_d.cat = SCS_CAT_HW;
      end else if (sw_fault) begin
        fault_d.cat = SCS_CAT_SW;
      end else begin
        fault_d.cat = SCS_CAT_USER;
      end
    end
    // gates depend on next state so blocking needs no software step
    gate_d  = (state_d == SCS_RUN && !fault_any) ?
              (pwm_in & chan_active_in) : RST_GATE;
    lamp_d  = lamp_of(state_d);
    panel_d = (state_d == SCS_HELD);
  end

  // state registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= RST_STATE;
      fault_q <= RST_FAULT;
      lamp_q  <= RST_LAMP;
      gate_q  <= RST_GATE;
      warn_q  <= 1'b0;
      hook_q  <= 1'b0;
      panel_q <= RST_PANEL;
    end else begin
      state_q <= state_d;
      fault_q <= fault_d;
      lamp_q  <= lamp_d;
      gate_q  <= gate_d;
      warn_q  <= warn_d;
      hook_q  <= hook_d;
      panel_q <= panel_d;
    end
  end

  // outputs straight from flip-flops
  assign gate_out         = gate_q;
  assign lamp_out         = lamp_q;
  assign state_out        = state_q;
  assign fault_out        = fault_q;
  assign warn_out         = warn_q;
  assign hook_invoke_out  = hook_q;
  assign panel_unlock_out = panel_q;

  // trip entry step sequence
  sequence trip_entry_s;
    state_q != SCS_TRIP ##1 state_q == SCS_TRIP;
  endsequence

  // notifications are a single pulse at entry
  sequence notify_pulse_s;
    hook_q && warn_q ##1 !hook_q && !warn_q;
  endsequence

  AST_FAULT_TRIPS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    fault_any |=> state_q == SCS_TRIP)
    else $error("fault did not trip");

  AST_FAULT_BEATS_ENABLE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (fault_any && enable_cmd_in && state_q == SCS_HELD) |=> state_q == SCS_TRIP)
    else $error("enable won over fault");

  AST_ENABLE_RUNS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == SCS_HELD && enable_cmd_in && !fault_any)
      |=> state_q == SCS_RUN && lamp_q == SCS_LAMP_GREEN)
    else $error("enable did not start running");

  AST_DISABLE_HOLDS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == SCS_RUN && disable_cmd_in && !fault_any)
      |=> state_q == SCS_HELD && gate_q == '0)
    else $error("disable did not inhibit");

  AST_GATE_ONLY_RUN: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (gate_q != '0) |-> state_q == SCS_RUN
      && (gate_q & ~$past(chan_active_in)) == '0)
    else $error("gate outside running or inactive channel");

  AST_LAMP_MATCH: assert property (
    @(posedge clk_in) disable iff (rst_in)
    lamp_q == lamp_of(state_q))
    else $error("lamp colour does not match state");

  AST_TRIP_NOTIFY: assert property (
    @(posedge clk_in) disable iff (rst_in)
    trip_entry_s |-> notify_pulse_s)
    else $error("trip entry not notified once");

  AST_ACK_NEEDS_CLEAR: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == SCS_TRIP && fault_any) |=> state_q == SCS_TRIP)
    else $error("fault acknowledged while present");

  AST_ACK_RETURNS: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == SCS_TRIP && hook_done_in && !fault_any)
      |=> state_q == SCS_HELD && fault_q.cat == SCS_CAT_NONE)
    else $error("acknowledge did not return to hold");

  AST_CAT_HW: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q != SCS_TRIP && hw_fault)
      |=> fault_q.cat == SCS_CAT_HW && fault_q.chan == first_chan($past(thr_sync)))
    else $error("hardware category or channel wrong");

  AST_PANEL_LOCK: assert property (
    @(posedge clk_in) disable iff (rst_in)
    panel_q == (state_q == SCS_HELD))
    else $error("panel lock mismatch");

endmodule

`default_nettype wire

/* testbench/scs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host console, trip hook and modulator stand-in facing the supervisor
module scs_host_model (
  input  wire logic                       clk_in,
  output logic                            enable_cmd_out,
  output logic                            disable_cmd_out,
  output logic                            hook_done_out,
  output logic      [scs_pkg::CH_NUM-1:0] pwm_out
);
  import scs_pkg::*;

  // idle levels from time zero
  initial begin
    enable_cmd_out = 1'b0;
    disable_cmd_out = 1'b0;
    hook_done_out = 1'b0;
    pwm_out = 8'h00;
  end

  // raw modulator pattern changes every cycle so stale gates show
  always @(posedge clk_in) begin
    #1 pwm_out <= pwm_out + 8'h5b;
  end

  // one-cycle pulse after gap idle cycles: 0 enable, 1 disable, 2 hook done
  task automatic pulse(input int sel, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    #1;
    enable_cmd_out = (sel == 0);
    disable_cmd_out = (sel == 1);
    hook_done_out = (sel == 2);
    @(posedge clk_in);
    #1;
    enable_cmd_out = 1'b0;
    disable_cmd_out = 1'b0;
    hook_done_out = 1'b0;
  endtask
endmodule

`default_nettype wire

/* testbench/tb_safety_core_state_machine.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_safety_core_state_machine;
  import scs_pkg::*;
  localparam int CLK_NS = 40;
  logic              clk;
  logic              rst;
  logic              en;
  logic              dis;
  logic              hk;
  logic [CH_NUM-1:0] thr;
  logic              ilk;
  scs_sw_err_t       sw;
  logic              haz;
  logic [CH_NUM-1:0] act;
  logic [CH_NUM-1:0] pwm;
  logic [CH_NUM-1:0] gate;
  logic [CH_NUM-1:0] exp_gate;
  scs_lamp_t         lamp;
  scs_state_t        st;
  scs_fault_t        flt;
  logic              warn;
  logic              hinv;
  logic              unl;
  int                fails;
  int                n_tests;
  int                n;

  scs_host_model host (
    .clk_in(clk), .enable_cmd_out(en), .disable_cmd_out(dis),
    .hook_done_out(hk), .pwm_out(pwm)
  );

  scs_core dut (
    .clk_in(clk), .rst_in(rst), .enable_cmd_in(en), .disable_cmd_in(dis),
    .thr_exceed_in(thr), .interlock_in(ilk), .sw_err_in(sw),
    .user_hazard_in(haz), .hook_done_in(hk), .chan_active_in(act),
    .pwm_in(pwm), .gate_out(gate), .lamp_out(lamp), .state_out(st),
    .fault_out(flt), .warn_out(warn), .hook_invoke_out(hinv),
    .panel_unlock_out(unl)
  );

  // clock and the gate value expected after the coming edge
  always #(CLK_NS/2) clk = ~clk;
  always @(negedge clk) exp_gate = pwm & act;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // wait a bounded number of edges for trip entry and judge the entry cycle
  task automatic wait_trip(output int cnt);
    cnt = 0;
    while (st !== SCS_TRIP && cnt < 10) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check("lamp_trip", lamp, SCS_LAMP_RED);
    check("gate_trip", gate, 8'h00);
    check("warn", warn, 1'b1);
    check("hook", hinv, 1'b1);
    @(posedge clk);
    #1;
    check("warn_end", {warn, hinv}, 2'b00);
  endtask

  // remove every cause, acknowledge and expect the held state
  task automatic recover;
    thr = 8'h00;
    ilk = 1'b1;
    sw = '0;
    haz = 1'b0;
    host.pulse(2, 6);
    check("ack_state", st, SCS_HELD);
    check("ack_fault", flt, RST_FAULT);
    check("ack_lamp", lamp, SCS_LAMP_ORANGE);
    check("ack_panel", unl, 1'b1);
  endtask

  task automatic t_reset;
    repeat (3) @(posedge clk);
    #1;
    check("rst_state", st, SCS_HELD);
    check("rst_gate", gate, 8'h00);
    check("rst_lamp", lamp, SCS_LAMP_ORANGE);
    check("rst_panel", unl, 1'b1);
  endtask

  task automatic t_run;
    host.pulse(0, 0);
    check("run_state", st, SCS_RUN);
    check("run_lamp", lamp, SCS_LAMP_GREEN);
    check("run_panel", unl, 1'b0);
    repeat (3) begin
      @(posedge clk);
      #1;
      check("run_gate", gate, exp_gate);
    end
    host.pulse(1, 0);
    check("dis_state", st, SCS_HELD);
    check("dis_gate", gate, 8'h00);
    host.pulse(0, 0);
    @(posedge clk);
    #1;
    check("reen_gate", gate, exp_gate);
  endtask

  task automatic t_user;
    @(posedge clk);
    #1;
    haz = 1'b1;
    wait_trip(n);
    check("user_lat", n[7:0], 8'h01);
    check("user_flt", flt, scs_fault_t'{SCS_CAT_USER, 1'b0, 3'h0, 1'b0});
    host.pulse(2, 0);
    check("ack_refused", st, SCS_TRIP);
    host.pulse(0, 0);
    check("en_in_trip", st, SCS_TRIP);
    recover();
  endtask

  task automatic t_sw;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      sw = scs_sw_err_t'(4'h8 >> i);
      wait_trip(n);
      check("sw_flt", flt.cat, SCS_CAT_SW);
      recover();
    end
  endtask

  task automatic t_pins;
    act = 8'h00;
    host.pulse(0, 0);
    thr = 8'h28;
    // hazard meets the synced threshold in the same cycle: hardware ranks first
    repeat (4) @(posedge clk);
    #1;
    haz = 1'b1;
    wait_trip(n);
    check("thr_flt", flt, scs_fault_t'{SCS_CAT_HW, 1'b1, 3'h3, 1'b0});
    recover();
    ilk = 1'b0;
    wait_trip(n);
    check("ilk_flt", flt, scs_fault_t'{SCS_CAT_HW, 1'b0, 3'h0, 1'b1});
    recover();
    act = 8'hff;
  endtask

  task automatic t_race;
    fork
      host.pulse(0, 0);
      begin
        @(posedge clk);
        #1;
        haz = 1'b1;
      end
    join
    check("race_state", st, SCS_TRIP);
    recover();
  endtask

  // watchdog against a hang
  initial begin
    #(CLK_NS * 5000);
    fails++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    thr = 8'h00;
    ilk = 1'b1;
    sw = '0;
    haz = 1'b0;
    act = 8'ha5;
    fails = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_run();
    t_user();
    t_sw();
    t_pins();
    t_race();
    complete_run();
  end
endmodule

`default_nettype wire
